// [bench/dspwm_load_model.sv]
`timescale 1ns/1ps
module dspwm_load_model (
  // pin from the timer
  input wire dspwm_pkg::dspwm_pin_t pin,
  // level seen by the load
  output logic line
);
  import dspwm_pkg::*;
  // released pin falls to the load's pull-down, never keeps the old level
  assign line = pin.oe ? pin.level : 1'b0;
endmodule // dspwm_load_model

// [bench/dspwm_timer_chk.sv]
`timescale 1ns/1ps
module dspwm_timer_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // pins
  input wire dspwm_pkg::dspwm_pin_t compare_out_a_pin,
  input wire dspwm_pkg::dspwm_pin_t compare_out_b_pin
);
  import dspwm_pkg::*;
  logic take;
  logic ph_wr;
  logic ph_rd;
  logic [31:0] ph_addr;
  logic [7:0] shadow;
  assign take = hsel && hready && htrans[1];
  // data phase tracking, so read data can be judged against earlier writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_wr <= 1'b0;
      ph_rd <= 1'b0;
      ph_addr <= 32'h0;
      shadow <= CTRL_A_RESET;
    end else if (hready) begin
      ph_wr <= take && hwrite;
      ph_rd <= take && !hwrite;
      ph_addr <= haddr;
      if (ph_wr && ph_addr == {24'h0, OFF_CTRL_A}) begin
        shadow <= hwdata[7:0] & CTRL_A_WMASK;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_READ_WAIT: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase is not one wait state");
  AST_WRITE_NOWAIT: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("response is not okay");
  AST_RDATA_HOLD: assert property (!$rose(hreadyout) |-> $stable(hrdata))
    else $error("read data moved outside a read completion");
  AST_CTRL_A_READ: assert property (ph_rd && hreadyout && ph_addr == {24'h0, OFF_CTRL_A}
    |-> hrdata == {24'h0, shadow})
    else $error("control a read differs from written value");
  AST_UNMAPPED_READ: assert property (ph_rd && hreadyout && ph_addr[31:8] != 24'h0
    |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_PIN_OE_A: assert property (ph_wr && hready && ph_addr == {24'h0, OFF_PORT}
    |-> ##2 compare_out_a_pin.oe == $past(hwdata[DIR_A], 2))
    else $error("pin a enable does not follow direction bit");
  AST_PIN_OE_B: assert property (ph_wr && hready && ph_addr == {24'h0, OFF_PORT}
    |-> ##2 compare_out_b_pin.oe == $past(hwdata[DIR_B], 2))
    else $error("pin b enable does not follow direction bit");
endmodule // dspwm_timer_chk

bind dspwm_timer dspwm_timer_chk i_dspwm_timer_chk (.clk, .rst_n, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .compare_out_a_pin,
  .compare_out_b_pin);

// [bench/dspwm_timer_tb.sv]
`timescale 1ns/1ps
module dspwm_timer_tb;
  import dspwm_pkg::*;
  logic clk, rst_n, hsel, hwrite, hreadyout, hresp, tick8, line_a, line_b;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  dspwm_pin_t pin_a, pin_b;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;

  dspwm_timer i_dspwm_timer (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .compare_out_a_pin(pin_a),
    .compare_out_b_pin(pin_b), .eight_bit_timer_clock_enable(tick8));
  dspwm_load_model i_dspwm_load_model (.pin(pin_a), .line(line_a));
  dspwm_load_model i_dspwm_load_model_b (.pin(pin_b), .line(line_b));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // whole run needs a few thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      err_count++;
      results();
    end
  end

  task results;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one single transfer; waits as long as hready stays low
  task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rv = hrdata;
  endtask

  // high counts over whole periods are exact whatever the phase
  task measure(input int n, input int ea, input int eb, input int et);
    int ha, hb, ht;
    ha = 0;
    hb = 0;
    ht = 0;
    repeat (n) begin
      @(posedge clk);
      ha += int'(line_a === 1'b1);
      hb += int'(line_b === 1'b1);
      ht += int'(tick8 === 1'b1);
    end
    chk(ha, ea, "high count a");
    chk(hb, eb, "high count b");
    chk(ht, et, "other timer enables");
  endtask

  // stopped while set up, so flags clear and buffers load from count zero
  task run(input logic [7:0] cb, input logic [7:0] ca, input logic [15:0] va,
      input logic [15:0] vb, input logic [3:0] port);
    bus(32'(OFF_CTRL_B), 1'b1, 32'h0);
    bus(32'(OFF_FLAGS), 1'b1, 32'hF);
    bus(32'(OFF_PORT), 1'b1, 32'(port));
    bus(32'(OFF_CMP_A), 1'b1, 32'(va));
    bus(32'(OFF_CMP_B), 1'b1, 32'(vb));
    bus(32'(OFF_CAPTURE), 1'b1, 32'h8);
    bus(32'(OFF_COUNTER), 1'b1, 32'h0);
    bus(32'(OFF_CTRL_A), 1'b1, 32'(ca));
    bus(32'(OFF_CTRL_B), 1'b1, 32'(cb));
    repeat (300) @(posedge clk);
  endtask

  task t_regs;
    bus(32'(OFF_CTRL_A), 1'b0, 32'h0);
    chk(rv, 32'(CTRL_A_RESET), "control a reset");
    bus(32'(OFF_CTRL_A), 1'b1, 32'hFF);
    bus(32'(OFF_CTRL_A), 1'b0, 32'h0);
    chk(rv, 32'hF3, "control a reserved bits");
    bus(32'h100, 1'b0, 32'h0);
    chk(rv, 32'h0, "unmapped read");
    bus(32'(OFF_CTRL_B), 1'b1, 32'h01);
    bus(32'(OFF_COUNTER), 1'b1, 32'h5);
    repeat (20) @(posedge clk);
    bus(32'(OFF_COUNTER), 1'b0, 32'h0);
    chk(rv, 32'h5, "counter moved outside dual slope");
  endtask

  task t_mode9;
    run(8'h31, 8'hA1, 16'h8, 16'h2, 4'h3);
    measure(64, 64, 16, 64);
    bus(32'(OFF_FLAGS), 1'b0, 32'h0);
    chk(rv, 32'h7, "flags in mode 9");
    run(8'h31, 8'hF1, 16'h8, 16'h2, 4'h3);
    measure(64, 0, 48, 64);
  endtask

  task t_mode8;
    run(8'h31, 8'hA0, 16'h2, 16'h6, 4'h3);
    measure(64, 16, 48, 64);
    bus(32'(OFF_FLAGS), 1'b0, 32'h0);
    chk(rv, 32'hF, "flags in mode 8");
  endtask

  task t_toggle;
    run(8'h31, 8'h51, 16'h8, 16'h2, 4'hB);
    measure(64, 32, 64, 64);
  endtask

  // top retuned through the buffered compare A while running
  task t_retune;
    run(8'h31, 8'hA1, 16'h8, 16'h2, 4'h3);
    bus(32'(OFF_CMP_A), 1'b1, 32'h6);
    repeat (100) @(posedge clk);
    measure(48, 48, 16, 48);
  endtask

  task t_dir;
    run(8'h31, 8'hA1, 16'h8, 16'h2, 4'h0);
    chk(32'(pin_a.oe), 32'h0, "pin a driven without direction");
    measure(64, 0, 0, 64);
  endtask

  task t_presc;
    run(8'h52, 8'hA1, 16'h8, 16'h2, 4'h3);
    measure(128, 128, 32, 16);
  endtask

  initial begin
    rst_n = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_mode9();
    t_mode8();
    t_toggle();
    t_retune();
    t_dir();
    t_presc();
    results();
  end
endmodule // dspwm_timer_tb

// [logic/dspwm_compare_unit.sv]
`timescale 1ns/1ps
module dspwm_compare_unit (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // counter side
  input wire logic step,
  input wire logic reload,
  input wire logic count_up,
  input wire logic [15:0] count,
  // configuration
  input wire logic [15:0] buf_value,
  input wire logic [1:0] out_mode,
  input wire logic toggle_ok,
  // results
  output logic [15:0] active_value,
  output logic match,
  output logic level
);
  import dspwm_pkg::*;

  logic [15:0] cmp_value;

  // a value reloaded at bottom is already compared there
  assign cmp_value = reload ? buf_value : active_value;
  assign match = step && (count == cmp_value);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_value <= 16'h0000;
    end else if (reload) begin
      active_value <= buf_value;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= 1'b0;
    end else if (match) begin
      unique case (out_mode)
        OUT_TOGGLE: level <= toggle_ok ? ~level : level;
        OUT_NONINV: level <= ~count_up;
        OUT_INV: level <= count_up;
        OUT_OFF: level <= level;
      endcase
    end
  end
endmodule // dspwm_compare_unit

// [logic/dspwm_prescaler.sv]
`timescale 1ns/1ps
module dspwm_prescaler (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // selections
  input wire logic [2:0] own_sel,
  input wire logic [2:0] other_sel,
  // enables
  output logic own_tick,
  output logic other_tick
);
  import dspwm_pkg::*;

  logic [9:0] div_reg;

  // one free divider serves both timers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 10'h000;
    end else begin
      div_reg <= div_reg + 10'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      own_tick <= 1'b0;
      other_tick <= 1'b0;
    end else begin
      own_tick <= dspwm_presc_tick(own_sel, div_reg);
      other_tick <= dspwm_presc_tick(other_sel, div_reg);
    end
  end
endmodule // dspwm_prescaler

// [logic/dspwm_timer.sv]
`timescale 1ns/1ps
module dspwm_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // compare output pins
  output dspwm_pkg::dspwm_pin_t compare_out_a_pin,
  output dspwm_pkg::dspwm_pin_t compare_out_b_pin,
  // enable for the eight-bit timer
  output logic eight_bit_timer_clock_enable
);
  import dspwm_pkg::*;

  // registers
  logic [7:0] timer1_control_a_reg;
  logic [7:0] control_b_reg;
  logic [15:0] counter_value_reg;
  logic [15:0] cmp_a_buf_reg;
  logic [15:0] cmp_b_buf_reg;
  logic [15:0] capture_register_reg;
  logic ovf_flag_reg;
  logic cmp_a_flag_reg;
  logic cmp_b_flag_reg;
  logic cap_flag_reg;
  logic [3:0] port_reg;
  dspwm_dir_t dir_reg;

  // bus data phase
  logic dp_write_reg;
  logic dp_read_reg;
  logic [7:0] dp_addr_reg;
  logic dp_mapped_reg;

  // derived
  logic ap_valid;
  logic [3:0] waveform_mode_field;
  logic [1:0] chan_a_output_mode;
  logic [1:0] chan_b_output_mode;
  logic pfc_mode;
  logic timer_clock_enable;
  logic step;
  logic [15:0] top_value;
  logic at_bottom;
  logic at_top;
  logic count_up;
  logic reload;
  logic toggle_ok;
  logic [15:0] chan_a_compare_value;
  logic [15:0] chan_b_active;
  logic match_a;
  logic match_b;
  logic level_a;
  logic level_b;
  logic connect_a;
  logic connect_b;
  logic wr_counter;
  logic wr_flags;
  logic [3:0] flags;
  logic [31:0] read_mux;

  function automatic logic wr_hit(input logic [7:0] off);
    return dp_write_reg && dp_mapped_reg && (dp_addr_reg == off);
  endfunction

  function automatic logic flag_next(input logic ev, input logic cur, input logic clr);
    return ev || (cur && !clr);
  endfunction

  // bus
  assign ap_valid = hsel && hready && htrans[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_write_reg <= 1'b0;
      dp_read_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
      dp_mapped_reg <= 1'b0;
    end else if (hready) begin
      dp_write_reg <= ap_valid && hwrite;
      dp_read_reg <= ap_valid && !hwrite;
      dp_addr_reg <= haddr[7:0];
      dp_mapped_reg <= (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
    end else begin
      dp_read_reg <= 1'b0;
    end
  end

  // reads take one wait state so a preceding write is always seen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
    end else if (ap_valid && !hwrite) begin
      hreadyout <= 1'b0;
    end else if (dp_read_reg) begin
      hreadyout <= 1'b1;
      hrdata <= read_mux;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  always_comb begin
    read_mux = 32'h0000_0000;
    if (dp_mapped_reg) begin
      unique case (dp_addr_reg)
        OFF_CTRL_A: read_mux = {24'h000000, timer1_control_a_reg};
        OFF_CTRL_B: read_mux = {24'h000000, control_b_reg};
        OFF_COUNTER: read_mux = {16'h0000, counter_value_reg};
        OFF_CMP_A: read_mux = {16'h0000, cmp_a_buf_reg};
        OFF_CMP_B: read_mux = {16'h0000, cmp_b_buf_reg};
        OFF_CAPTURE: read_mux = {16'h0000, capture_register_reg};
        OFF_FLAGS: read_mux = {28'h0000000, flags};
        OFF_PORT: read_mux = {28'h0000000, port_reg};
        default: read_mux = 32'h0000_0000;
      endcase
    end
  end

  // registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer1_control_a_reg <= CTRL_A_RESET;
    end else if (wr_hit(OFF_CTRL_A)) begin
      // bits 3:2 are reserved and stay zero
      timer1_control_a_reg <= hwdata[7:0] & CTRL_A_WMASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      control_b_reg <= CTRL_B_RESET;
    end else if (wr_hit(OFF_CTRL_B)) begin
      control_b_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_a_buf_reg <= 16'h0000;
      cmp_b_buf_reg <= 16'h0000;
      capture_register_reg <= 16'h0000;
    end else begin
      if (wr_hit(OFF_CMP_A)) begin
        cmp_a_buf_reg <= hwdata[15:0];
      end
      if (wr_hit(OFF_CMP_B)) begin
        cmp_b_buf_reg <= hwdata[15:0];
      end
      if (wr_hit(OFF_CAPTURE)) begin
        capture_register_reg <= hwdata[15:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_reg <= PORT_RESET;
    end else if (wr_hit(OFF_PORT)) begin
      port_reg <= hwdata[3:0];
    end
  end

  // mode decode
  assign waveform_mode_field = {control_b_reg[WAVE_HI_LSB +: 2],
                                timer1_control_a_reg[WAVE_LO_LSB +: 2]};
  assign chan_a_output_mode = timer1_control_a_reg[CHA_MODE_LSB +: 2];
  assign chan_b_output_mode = timer1_control_a_reg[CHB_MODE_LSB +: 2];
  // other waveform modes are not built here; the counter then holds
  assign pfc_mode = (waveform_mode_field == WAVE_PFC_CAP)
                 || (waveform_mode_field == WAVE_PFC_CMPA);
  assign toggle_ok = (waveform_mode_field == WAVE_PFC_CMPA)
                  || (waveform_mode_field == WAVE_PC_CMPA);

  // in mode 9 top follows the active compare A value, so retuning waits for bottom;
  // on the reloading step the buffered value already decides, as for matches
  assign top_value = (waveform_mode_field != WAVE_PFC_CMPA) ? capture_register_reg
                   : (reload ? cmp_a_buf_reg : chan_a_compare_value);

  // prescaler
  dspwm_prescaler u_prescaler (
    .clk(clk),
    .rst_n(rst_n),
    .own_sel(control_b_reg[OWN_SEL_LSB +: 3]),
    .other_sel(control_b_reg[OTHER_SEL_LSB +: 3]),
    .own_tick(timer_clock_enable),
    .other_tick(eight_bit_timer_clock_enable)
  );

  assign wr_counter = wr_hit(OFF_COUNTER);
  // a software write to the counter takes the place of a step
  assign step = timer_clock_enable && pfc_mode && !wr_counter;

  // counter
  assign at_bottom = (counter_value_reg == BOTTOM);
  assign at_top = (counter_value_reg == top_value);
  // at the turning points the coming slope decides the action
  assign count_up = at_bottom ? 1'b1
                  : (at_top ? 1'b0 : (dir_reg == DSPWM_UP));
  assign reload = step && at_bottom;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_value_reg <= BOTTOM;
      dir_reg <= DSPWM_UP;
    end else if (wr_counter) begin
      counter_value_reg <= hwdata[15:0];
    end else if (step) begin
      if (dir_reg == DSPWM_UP) begin
        // >= keeps a lowered top from letting the count run away
        if (counter_value_reg >= top_value) begin
          dir_reg <= DSPWM_DOWN;
          counter_value_reg <= counter_value_reg - 16'h0001;
        end else begin
          counter_value_reg <= counter_value_reg + 16'h0001;
        end
      end else if (at_bottom) begin
        dir_reg <= DSPWM_UP;
        counter_value_reg <= counter_value_reg + 16'h0001;
      end else begin
        counter_value_reg <= counter_value_reg - 16'h0001;
      end
    end
  end

  // compare units
  dspwm_compare_unit u_cmp_a (
    .clk(clk),
    .rst_n(rst_n),
    .step(step),
    .reload(reload),
    .count_up(count_up),
    .count(counter_value_reg),
    .buf_value(cmp_a_buf_reg),
    .out_mode(chan_a_output_mode),
    .toggle_ok(toggle_ok),
    .active_value(chan_a_compare_value),
    .match(match_a),
    .level(level_a)
  );

  dspwm_compare_unit u_cmp_b (
    .clk(clk),
    .rst_n(rst_n),
    .step(step),
    .reload(reload),
    .count_up(count_up),
    .count(counter_value_reg),
    .buf_value(cmp_b_buf_reg),
    .out_mode(chan_b_output_mode),
    .toggle_ok(1'b0),
    .active_value(chan_b_active),
    .match(match_b),
    .level(level_b)
  );

  // flags
  assign wr_flags = wr_hit(OFF_FLAGS);
  assign flags[FLG_OVF] = ovf_flag_reg;
  assign flags[FLG_CMP_A] = cmp_a_flag_reg;
  assign flags[FLG_CMP_B] = cmp_b_flag_reg;
  assign flags[FLG_CAP] = cap_flag_reg;

  // a set in the same cycle as the clear wins, so no event is lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_flag_reg <= 1'b0;
    end else begin
      ovf_flag_reg <= flag_next(reload, ovf_flag_reg,
                                wr_flags && hwdata[FLG_OVF]);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_a_flag_reg <= 1'b0;
    end else begin
      cmp_a_flag_reg <= flag_next(match_a, cmp_a_flag_reg,
                                  wr_flags && hwdata[FLG_CMP_A]);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_b_flag_reg <= 1'b0;
    end else begin
      cmp_b_flag_reg <= flag_next(match_b, cmp_b_flag_reg,
                                  wr_flags && hwdata[FLG_CMP_B]);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_flag_reg <= 1'b0;
    end else begin
      cap_flag_reg <= flag_next(step && at_top && (waveform_mode_field == WAVE_PFC_CAP),
                                cap_flag_reg, wr_flags && hwdata[FLG_CAP]);
    end
  end

  // pins
  // toggle on channel B, or outside modes 9 and 11, leaves the port
  assign connect_a = (chan_a_output_mode == OUT_NONINV)
                  || (chan_a_output_mode == OUT_INV)
                  || ((chan_a_output_mode == OUT_TOGGLE) && toggle_ok);
  assign connect_b = chan_b_output_mode[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_out_a_pin <= '0;
      compare_out_b_pin <= '0;
    end else begin
      compare_out_a_pin.level <= connect_a ? level_a : port_reg[DATA_A];
      compare_out_a_pin.oe <= port_reg[DIR_A];
      compare_out_b_pin.level <= connect_b ? level_b : port_reg[DATA_B];
      compare_out_b_pin.oe <= port_reg[DIR_B];
    end
  end
endmodule // dspwm_timer

// [pkg/dspwm_pkg.sv]
package dspwm_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL_A = 8'h80;
  localparam logic [7:0] OFF_CTRL_B = 8'h84;
  localparam logic [7:0] OFF_COUNTER = 8'h88;
  localparam logic [7:0] OFF_CMP_A = 8'h8C;
  localparam logic [7:0] OFF_CMP_B = 8'h90;
  localparam logic [7:0] OFF_CAPTURE = 8'h94;
  localparam logic [7:0] OFF_FLAGS = 8'h98;
  localparam logic [7:0] OFF_PORT = 8'h9C;

  // timer1_control_a fields
  localparam int CHA_MODE_LSB = 6;
  localparam int CHB_MODE_LSB = 4;
  localparam int WAVE_LO_LSB = 0;
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_A_WMASK = 8'hF3;

  // second control register fields
  localparam int OWN_SEL_LSB = 0;
  localparam int WAVE_HI_LSB = 3;
  localparam int OTHER_SEL_LSB = 5;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;

  // flag register bits, write one to clear
  localparam int FLG_OVF = 0;
  localparam int FLG_CMP_A = 1;
  localparam int FLG_CMP_B = 2;
  localparam int FLG_CAP = 3;

  // port register bits
  localparam int DIR_A = 0;
  localparam int DIR_B = 1;
  localparam int DATA_A = 2;
  localparam int DATA_B = 3;
  localparam logic [3:0] PORT_RESET = 4'h0;

  // waveform and output modes
  localparam logic [3:0] WAVE_PFC_CAP = 4'h8;
  localparam logic [3:0] WAVE_PFC_CMPA = 4'h9;
  localparam logic [3:0] WAVE_PC_CMPA = 4'hB;
  localparam logic [1:0] OUT_OFF = 2'h0;
  localparam logic [1:0] OUT_TOGGLE = 2'h1;
  localparam logic [1:0] OUT_NONINV = 2'h2;
  localparam logic [1:0] OUT_INV = 2'h3;

  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [15:0] TOP_MIN = 16'h0003;

  // prescale selections: 0 stops the timer
  localparam logic [2:0] PS_STOP = 3'h0;
  localparam logic [2:0] PS_DIV1 = 3'h1;
  localparam logic [2:0] PS_DIV8 = 3'h2;
  localparam logic [2:0] PS_DIV64 = 3'h3;
  localparam logic [2:0] PS_DIV256 = 3'h4;
  localparam logic [2:0] PS_DIV1024 = 3'h5;

  typedef enum logic {DSPWM_UP, DSPWM_DOWN} dspwm_dir_t;

  typedef struct packed {
    logic level;
    logic oe;
  } dspwm_pin_t;

  function automatic logic dspwm_presc_tick(input logic [2:0] sel, input logic [9:0] cnt);
    unique case (sel)
      PS_DIV1: return 1'b1;
      PS_DIV8: return &cnt[2:0];
      PS_DIV64: return &cnt[5:0];
      PS_DIV256: return &cnt[7:0];
      PS_DIV1024: return &cnt;
      default: return 1'b0;
    endcase
  endfunction

endpackage
